// ---- hdl/codec_ctrl_pkg.sv ----
// Purpose: Constants and carriers for the codec control register bank
// Assumes: Byte-wide registers on register page 0, 8-bit addresses
// Notes: Offsets are byte addresses within page 0
package codec_ctrl_pkg;
   localparam logic [7:0] LEVEL_WATCH_CHANNELS_OFS = 8'h50;
   localparam logic [7:0] LEVEL_WATCH_THRESHOLD_OFS = 8'h51;
   localparam logic [7:0] MIC_ONE_CONTROL_OFS = 8'hb4;
   localparam logic [7:0] MIC_ONE_GAIN_OFS = 8'hb5;
   localparam logic [7:0] MIC_ONE_ROUTE_OFS = 8'hb7;
   localparam logic [7:0] MIC_TWO_CONTROL_OFS = 8'hb8;
   localparam logic [7:0] MIC_TWO_GAIN_OFS = 8'hb9;
   localparam logic [7:0] MIC_TWO_ROUTE_OFS = 8'hbb;
   localparam logic [7:0] IO_SUPPLY_RANGE_OFS = 8'he0;
   localparam logic [7:0] CORE_REGULATOR_CONTROL_OFS = 8'he1;
   localparam logic [7:0] LEVEL_WATCH_MASK_OFS = 8'h4c;

   localparam int IO_RANGE_POS = 0;
   localparam int REG_ENABLE_POS = 7;
   localparam int REG_LEVEL_LSB = 4;
   localparam int MIC_ENABLE_POS = 7;
   localparam int MIC_MUTE_POS = 6;
   localparam int LEVEL_MASK_POS = 0;

   localparam logic [3:0] CHANNELS_RESET = 4'h0;
   localparam logic [6:0] THRESHOLD_RESET = 7'h7f;
   localparam logic [2:0] GAIN_RESET = 3'h1;
   localparam logic [1:0] ROUTE_RESET = 2'h0;
   localparam logic [1:0] REG_LEVEL_RESET = 2'h0;
   localparam logic MUTE_RESET = 1'b1;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic IO_RANGE_RESET = 1'b0;
   localparam logic LEVEL_MASK_RESET = 1'b0;

   typedef struct packed {
      logic enable;
      logic mute;
      logic [2:0] gain;
      logic [1:0] route;
   } mic_ctrl_t;

   typedef struct packed {
      logic ioRange;
      logic regEnable;
      logic [1:0] regLevel;
      logic [3:0] channelEnable;
      logic [6:0] threshold;
      mic_ctrl_t micOne;
      mic_ctrl_t micTwo;
   } ctrl_out_t;
endpackage

// ---- hdl/mic_channel_regs.sv ----
// Purpose: Control, gain and route registers of one microphone channel
// Assumes: Write strobe and data come from the control interface clock
// Notes: Reserved bits read as zero
`timescale 1ns/10ps
module mic_channel_regs (
   input wire logic clock,
   input wire logic rst,
   input wire logic ctrlWrite,
   input wire logic gainWrite,
   input wire logic routeWrite,
   input wire logic [7:0] writeData,
   output codec_ctrl_pkg::mic_ctrl_t micCtrl,
   output logic [7:0] ctrlRead,
   output logic [7:0] gainRead,
   output logic [7:0] routeRead
);
   import codec_ctrl_pkg::*;

   logic enable_reg;
   logic mute_reg;
   logic [2:0] gain_reg;
   logic [1:0] route_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         enable_reg <= ENABLE_RESET;
         mute_reg <= MUTE_RESET;
      end else if (ctrlWrite) begin
         enable_reg <= writeData[MIC_ENABLE_POS];
         mute_reg <= writeData[MIC_MUTE_POS];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gain_reg <= GAIN_RESET;
      end else if (gainWrite) begin
         gain_reg <= writeData[2:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         route_reg <= ROUTE_RESET;
      end else if (routeWrite) begin
         route_reg <= writeData[1:0];
      end
   end

   assign micCtrl = '{enable: enable_reg, mute: mute_reg, gain: gain_reg, route: route_reg};
   assign ctrlRead = {enable_reg, mute_reg, 6'h00};
   assign gainRead = {5'h00, gain_reg};
   assign routeRead = {6'h00, route_reg};
endmodule

// ---- hdl/codec_ctrl_regs.sv ----
// Purpose: Control register bank of the codec, register page 0
// Assumes: Control interface delivers decoded page-0 byte accesses
// Notes: Reads are combinational on regAddr
//
// How it works
// - I/O supply range bit, reset zero
// - Core regulator enable bit seven, reset zero
// - Two-bit regulator voltage select, reset zero
// - Four level watch channel enables
// - Seven-bit threshold, resets to full scale
// - Above threshold, level control enters anti-clip
// - Mic one preamp enable, reset zero
// - Mic one preamp mute, reset muted
// - Mic one gain three bits, reset 0 dB
// - Mic route select two bits, reset differential
// - Unmasked level events drive low interrupt
`timescale 1ns/10ps
module codec_ctrl_regs (
   input wire logic clock,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] writeData,
   output logic [7:0] readData,
   output logic addrHit,
   input wire logic [3:0] levelAbove,
   input wire logic levelEvent,
   output logic antiClip,
   output logic irq_out_n,
   output codec_ctrl_pkg::ctrl_out_t ctrlOut
);
   import codec_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic ioRange_reg;
   logic regEnable_reg;
   logic [1:0] regLevel_reg;
   logic [3:0] channels_reg;
   logic [6:0] threshold_reg;
   logic levelMask_reg;
   logic [3:0] aboveSync1_reg;
   logic [3:0] aboveSync2_reg;
   logic eventSync1_reg;
   logic eventSync2_reg;
   logic antiClip_reg;
   logic irqN_reg;
   mic_ctrl_t micOne;
   mic_ctrl_t micTwo;
   logic [7:0] oneCtrlRd;
   logic [7:0] oneGainRd;
   logic [7:0] oneRouteRd;
   logic [7:0] twoCtrlRd;
   logic [7:0] twoGainRd;
   logic [7:0] twoRouteRd;

   ////////////////////////////////////////////////////////////////////////
   // Supply and regulator

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ioRange_reg <= IO_RANGE_RESET;
      end else if (regWrite && hit(regAddr, IO_SUPPLY_RANGE_OFS)) begin
         ioRange_reg <= writeData[IO_RANGE_POS];
      end
   end

   // Regulator needs master bias, kept by software
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regEnable_reg <= ENABLE_RESET;
         regLevel_reg <= REG_LEVEL_RESET;
      end else if (regWrite && hit(regAddr, CORE_REGULATOR_CONTROL_OFS)) begin
         regEnable_reg <= writeData[REG_ENABLE_POS];
         regLevel_reg <= writeData[REG_LEVEL_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Level watch

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         channels_reg <= CHANNELS_RESET;
      end else if (regWrite && hit(regAddr, LEVEL_WATCH_CHANNELS_OFS)) begin
         channels_reg <= writeData[3:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         threshold_reg <= THRESHOLD_RESET;
      end else if (regWrite && hit(regAddr, LEVEL_WATCH_THRESHOLD_OFS)) begin
         threshold_reg <= writeData[6:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         levelMask_reg <= LEVEL_MASK_RESET;
      end else if (regWrite && hit(regAddr, LEVEL_WATCH_MASK_OFS)) begin
         levelMask_reg <= writeData[LEVEL_MASK_POS];
      end
   end

   // Detector flags come from the analog side
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aboveSync1_reg <= 4'h0;
         aboveSync2_reg <= 4'h0;
         eventSync1_reg <= 1'b0;
         eventSync2_reg <= 1'b0;
      end else begin
         aboveSync1_reg <= levelAbove;
         aboveSync2_reg <= aboveSync1_reg;
         eventSync1_reg <= levelEvent;
         eventSync2_reg <= eventSync1_reg;
      end
   end

   // Only enabled channels steer the level control
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         antiClip_reg <= 1'b0;
      end else begin
         antiClip_reg <= |(aboveSync2_reg & channels_reg);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqN_reg <= 1'b1;
      end else begin
         irqN_reg <= ~(eventSync2_reg & ~levelMask_reg);
      end
   end

   assign antiClip = antiClip_reg;
   assign irq_out_n = irqN_reg;

   ////////////////////////////////////////////////////////////////////////
   // Microphone channels

   mic_channel_regs micOneRegs (
      .clock(clock),
      .rst(rst),
      .ctrlWrite(regWrite && hit(regAddr, MIC_ONE_CONTROL_OFS)),
      .gainWrite(regWrite && hit(regAddr, MIC_ONE_GAIN_OFS)),
      .routeWrite(regWrite && hit(regAddr, MIC_ONE_ROUTE_OFS)),
      .writeData(writeData),
      .micCtrl(micOne),
      .ctrlRead(oneCtrlRd),
      .gainRead(oneGainRd),
      .routeRead(oneRouteRd)
   );

   mic_channel_regs micTwoRegs (
      .clock(clock),
      .rst(rst),
      .ctrlWrite(regWrite && hit(regAddr, MIC_TWO_CONTROL_OFS)),
      .gainWrite(regWrite && hit(regAddr, MIC_TWO_GAIN_OFS)),
      .routeWrite(regWrite && hit(regAddr, MIC_TWO_ROUTE_OFS)),
      .writeData(writeData),
      .micCtrl(micTwo),
      .ctrlRead(twoCtrlRd),
      .gainRead(twoGainRd),
      .routeRead(twoRouteRd)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read back, reserved bits zero

   always_comb begin
      readData = 8'h00;
      addrHit = 1'b1;
      unique case (regAddr)
         IO_SUPPLY_RANGE_OFS: readData = {7'h00, ioRange_reg};
         CORE_REGULATOR_CONTROL_OFS: readData = {regEnable_reg, 1'b0, regLevel_reg, 4'h0};
         LEVEL_WATCH_CHANNELS_OFS: readData = {4'h0, channels_reg};
         LEVEL_WATCH_THRESHOLD_OFS: readData = {1'b0, threshold_reg};
         LEVEL_WATCH_MASK_OFS: readData = {7'h00, levelMask_reg};
         MIC_ONE_CONTROL_OFS: readData = oneCtrlRd;
         MIC_ONE_GAIN_OFS: readData = oneGainRd;
         MIC_ONE_ROUTE_OFS: readData = oneRouteRd;
         MIC_TWO_CONTROL_OFS: readData = twoCtrlRd;
         MIC_TWO_GAIN_OFS: readData = twoGainRd;
         MIC_TWO_ROUTE_OFS: readData = twoRouteRd;
         default: addrHit = 1'b0;
      endcase
   end

   always_comb begin
      ctrlOut.ioRange = ioRange_reg;
      ctrlOut.regEnable = regEnable_reg;
      ctrlOut.regLevel = regLevel_reg;
      ctrlOut.channelEnable = channels_reg;
      ctrlOut.threshold = threshold_reg;
      ctrlOut.micOne = micOne;
      ctrlOut.micTwo = micTwo;
   end
endmodule

// ---- bench/codec_ctrl_regs_monitor.sv ----
// Purpose: Port checker for codec_ctrl_regs
// Assumes: One clock, async high reset
// Notes: Bound below
`timescale 1ns/10ps
module codec_ctrl_regs_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] writeData,
   input wire logic [7:0] readData,
   input wire logic addrHit,
   input wire logic [3:0] levelAbove,
   input wire logic levelEvent,
   input wire logic antiClip,
   input wire logic irq_out_n,
   input wire codec_ctrl_pkg::ctrl_out_t ctrlOut
);
   import codec_ctrl_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   property p_io;
      regWrite && regAddr == IO_SUPPLY_RANGE_OFS |=> ctrlOut.ioRange == $past(writeData[0]);
   endproperty
   a_io: assert property (p_io) else $error("io range");
   property p_ldo;
      regWrite && regAddr == CORE_REGULATOR_CONTROL_OFS
         |=> {ctrlOut.regEnable, ctrlOut.regLevel} == $past({writeData[7], writeData[5:4]});
   endproperty
   a_ldo: assert property (p_ldo) else $error("regulator");
   property p_chan;
      regWrite && regAddr == LEVEL_WATCH_CHANNELS_OFS |=> ctrlOut.channelEnable == $past(writeData[3:0]);
   endproperty
   a_chan: assert property (p_chan) else $error("channels");
   property p_thr;
      regWrite && regAddr == LEVEL_WATCH_THRESHOLD_OFS |=> ctrlOut.threshold == $past(writeData[6:0]);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold");
   property p_ctrl;
      regWrite && regAddr == MIC_ONE_CONTROL_OFS
         |=> {ctrlOut.micOne.enable, ctrlOut.micOne.mute} == $past(writeData[7:6]);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("mic control");
   property p_gain;
      regWrite && regAddr == MIC_ONE_GAIN_OFS |=> ctrlOut.micOne.gain == $past(writeData[2:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("mic gain");
   property p_route;
      regWrite && regAddr == MIC_TWO_ROUTE_OFS |=> ctrlOut.micTwo.route == $past(writeData[1:0]);
   endproperty
   a_route: assert property (p_route) else $error("mic route");
   property p_resv;
      regAddr == MIC_ONE_GAIN_OFS |-> readData[7:3] == 5'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits");
   property p_miss;
      !addrHit |-> readData == 8'h00;
   endproperty
   a_miss: assert property (p_miss) else $error("unmapped read");
   property p_irq;
      (!levelEvent) [*4] |=> irq_out_n;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without event");
   property p_clip;
      (levelAbove == 4'h0) [*4] |=> !antiClip;
   endproperty
   a_clip: assert property (p_clip) else $error("anti-clip without level");
   ////////////////////////////////////////////////////////////
   c_wr: cover property (regWrite && regAddr == MIC_TWO_GAIN_OFS);
   c_irq: cover property (!irq_out_n);
   c_clip: cover property (antiClip);
endmodule
bind codec_ctrl_regs codec_ctrl_regs_monitor codec_ctrl_regs_monitor_i (.clock, .rst, .regWrite, .regAddr,
   .writeData, .readData, .addrHit, .levelAbove, .levelEvent, .antiClip, .irq_out_n, .ctrlOut);

// ---- bench/codec_ctrl_regs_tb_top.sv ----
// Purpose: Register and detector tests of codec_ctrl_regs
// Assumes: Byte writes by one-cycle strobe
// Notes: Reads compared at the falling edge
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module codec_ctrl_regs_tb_top;
   import codec_ctrl_pkg::*;
   localparam logic [7:0] ADR [10] = '{8'h50, 8'h51, 8'hb4, 8'hb5, 8'hb7, 8'hb8, 8'hb9, 8'hbb, 8'he0, 8'he1};
   localparam logic [7:0] RST [10] = '{8'h00, 8'h7f, 8'h40, 8'h01, 8'h00, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] MSK [10] = '{8'h0f, 8'h7f, 8'hc0, 8'h07, 8'h03, 8'hc0, 8'h07, 8'h03, 8'h01, 8'hb0};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic regWrite = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] writeData = 8'h00;
   logic [3:0] levelAbove = 4'h0;
   logic levelEvent = 1'b0;
   logic [7:0] readData;
   logic addrHit;
   logic antiClip;
   logic irq_out_n;
   ctrl_out_t ctrlOut;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   int i;
   logic [7:0] v;
   codec_ctrl_regs codec_ctrl_regs_i (.clock(clock), .rst(rst), .regWrite(regWrite), .regAddr(regAddr),
      .writeData(writeData), .readData(readData), .addrHit(addrHit), .levelAbove(levelAbove),
      .levelEvent(levelEvent), .antiClip(antiClip), .irq_out_n(irq_out_n), .ctrlOut(ctrlOut));
   ////////////////////////////////////////////////////////////
   initial begin
      forever #5 clock = ~clock;
   end
   task end_sim;
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         end_sim;
      end
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      writeData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      regAddr <= a;
      @(negedge clock);
      `CHK(readData, e)
   endtask
   task pause;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 10; i++) rd(ADR[i], RST[i]);
      // Master bias taken as on before the regulator write
      for (i = 0; i < 10; i++) wr(ADR[i], 8'hff);
      for (i = 0; i < 10; i++) rd(ADR[i], MSK[i]);
      `CHK(ctrlOut, {1'b1, 1'b1, 2'h3, 4'hf, 7'h7f, 7'h7f, 7'h7f})
      wr(8'h52, 8'hff);
      rd(8'h52, 8'h00);
      `CHK(addrHit, 1'b0)
      for (v = 0; v < 8; v++) begin
         wr(8'hb5, v);
         wr(8'hb9, ~v);
         rd(8'hb5, v);
         rd(8'hb9, {5'h00, ~v[2:0]});
      end
      for (v = 0; v < 4; v++) begin
         wr(8'hb7, v);
         wr(8'hbb, v);
         wr(8'he1, {2'h0, v[1:0], 4'h0});
         rd(8'hb7, v);
         rd(8'hbb, v);
         rd(8'he1, {2'h0, v[1:0], 4'h0});
      end
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 10; i++) rd(ADR[i], RST[i]);
      wr(8'h50, 8'h01);
      levelAbove <= 4'h1;
      pause;
      `CHK(antiClip, 1'b1)
      @(posedge clock);
      levelAbove <= 4'h2;
      pause;
      `CHK(antiClip, 1'b0)
      `CHK(irq_out_n, 1'b1)
      @(posedge clock);
      levelEvent <= 1'b1;
      pause;
      `CHK(irq_out_n, 1'b0)
      wr(8'h4c, 8'h01);
      pause;
      `CHK(irq_out_n, 1'b1)
      end_sim;
   end
endmodule
